// *** design/sadc_pkg.sv ***
package sadc_pkg;

  // Frame layout: twelve result bits above four trailing pad bits.
  localparam int             RESULT_W     = 12;
  localparam int             FRAME_W      = 16;
  localparam int             CNT_W        = 6;
  localparam int             MUXCNT_W     = 4;
  localparam logic [5:0]     FRAME_BITS   = 6'h10;
  localparam logic [3:0]     PAD_BITS     = 4'h0;
  localparam logic [11:0]    ZERO_CODE    = 12'h000;
  localparam logic [11:0]    FULL_CODE    = 12'hFFF;

  // Cycle timing in serial clocks.
  localparam logic [5:0]     SAMPLE_FIRST = 6'h05;
  localparam logic [5:0]     SAMPLE_CLKS  = 6'h0C;
  localparam logic [5:0]     CONV_CLKS    = 6'h1C;
  localparam logic [5:0]     HOLD_EXTRA   = 6'h01;
  localparam logic [5:0]     HOLD_TOTAL   = FRAME_BITS + CONV_CLKS + HOLD_EXTRA;

  // Multiplexer reset window, counted in serial clocks while chip select is low.
  localparam logic [3:0]     MUX_SHORT_MIN = 4'h4;
  localparam logic [3:0]     MUX_SHORT_MAX = 4'h7;
  localparam logic [3:0]     MUX_SAT       = 4'h8;

  // Serial clock made by the host from the 50 MHz system clock.
  localparam int             CLK_HZ       = 50_000_000;
  localparam int             SCLK_HZ      = 2_500_000;
  localparam int             HALF_CYC_INT = CLK_HZ / (2 * SCLK_HZ);
  localparam logic [3:0]     SCLK_HALF    = 4'(HALF_CYC_INT - 1);

  typedef enum logic [1:0] {SADC_SINGLE, SADC_DUAL, SADC_PSEUDO} sadc_variant_t;
  typedef enum logic [1:0] {SADC_CTRL_CS, SADC_CTRL_FS, SADC_CTRL_BOTH} sadc_ctrl_t;
  typedef enum logic [1:0] {DS_DOWN, DS_ARMED, DS_ACTIVE, DS_CONV} sadc_dev_st_t;
  typedef enum logic [1:0] {HS_IDLE, HS_LEAD, HS_PULSE, HS_FRAME} sadc_host_st_t;

endpackage

// *** design/sadc_if.sv ***
`timescale 1ns/100ps
interface sadc_if;
  logic sclk;
  logic cs_n;
  logic frame_sync_in;
  logic sdo;
  logic sdo_oe;
  logic sdo_seen;

  // The released line reads low, as with a weak pull-down on the board.
  assign sdo_seen = sdo_oe & sdo;

  modport dev (input sclk, input cs_n, input frame_sync_in, output sdo, output sdo_oe);
  modport hst (output sclk, output cs_n, output frame_sync_in, input sdo_seen);
endinterface

// *** design/sadc_host.sv ***
`timescale 1ns/100ps
module sadc_host (
  input  wire logic                 clk,
  input  wire logic                 rst_n,
  sadc_if.hst                       bus,
  input  wire logic                 start,
  input  wire sadc_pkg::sadc_ctrl_t ctrl_mode,
  output logic                      busy,
  output logic                      result_valid,
  output logic [11:0]               result_data
);

  typedef struct packed {
    logic [3:0]              div;
    logic                    sclk;
    logic                    cs_n;
    logic                    fs;
    logic                    s1;
    logic                    s2;
    logic                    s3;
    logic                    flt;
    sadc_pkg::sadc_host_st_t st;
    sadc_pkg::sadc_ctrl_t    mode;
    logic [5:0]              fcnt;
    logic [15:0]             shreg;
    logic                    busy;
    logic                    valid;
    logic [11:0]             data;
  } sadc_host_t;

  sadc_host_t r;
  sadc_host_t n;
  logic       rise_tick;
  logic       fall_tick;

  ////////////////////////////////////////////////////////////////////////////
  // The serial clock runs free, so a falling edge occurs while chip select is high, except in SADC_CTRL_FS mode, where select stays low.
  always_comb
  begin
    n = r;
    n.valid = 1'b0;
    rise_tick = 1'b0;
    fall_tick = 1'b0;
    n.s1 = bus.sdo_seen;
    n.s2 = r.s1;
    n.s3 = r.s2;
    if (r.s2 == r.s3)
    begin
      n.flt = r.s3;
    end
    if (r.div == sadc_pkg::SCLK_HALF)
    begin
      n.div = 4'h0;
      n.sclk = ~r.sclk;
      rise_tick = ~r.sclk;
      fall_tick = r.sclk;
    end
    else
    begin
      n.div = r.div + 4'h1;
    end
    case (r.st)
      sadc_pkg::HS_IDLE:
      begin
        // Idle levels follow the requested mode, so a change of mode settles the lines before the next start.
        n.cs_n = (ctrl_mode != sadc_pkg::SADC_CTRL_FS);
        n.fs = (ctrl_mode == sadc_pkg::SADC_CTRL_CS);
        if (start)
        begin
          n.mode = ctrl_mode;
          n.fcnt = 6'h00;
          n.busy = 1'b1;
          n.st = sadc_pkg::HS_LEAD;
        end
      end
      sadc_pkg::HS_LEAD:
      begin
        // Control lines move only on rising edges, and only after a falling edge has passed since start.
        if (fall_tick)
        begin
          n.fcnt = 6'h01;
        end
        if (rise_tick && r.fcnt != 6'h00)
        begin
          n.fcnt = 6'h00;
          n.cs_n = 1'b0;
          n.fs = (r.mode != sadc_pkg::SADC_CTRL_BOTH);
          n.st = (r.mode == sadc_pkg::SADC_CTRL_CS) ? sadc_pkg::HS_FRAME : sadc_pkg::HS_PULSE;
        end
      end
      sadc_pkg::HS_PULSE:
      begin
        // Frame sync is high for one serial clock and falls while the clock is high.
        if (rise_tick)
        begin
          n.fs = (r.mode == sadc_pkg::SADC_CTRL_BOTH) && !r.fs;
          if (r.fs)
          begin
            n.st = sadc_pkg::HS_FRAME;
          end
        end
      end
      sadc_pkg::HS_FRAME:
      begin
        // Capture on falling edges, then hold the line low through conversion plus one clock.
        if (fall_tick && r.fcnt != sadc_pkg::HOLD_TOTAL)
        begin
          n.fcnt = r.fcnt + 6'h01;
          if (r.fcnt < sadc_pkg::FRAME_BITS)
          begin
            n.shreg = {r.shreg[14:0], r.flt};
          end
        end
        if (rise_tick && r.fcnt == sadc_pkg::HOLD_TOTAL)
        begin
          n.cs_n = (r.mode != sadc_pkg::SADC_CTRL_FS);
          n.valid = 1'b1;
          n.data = r.shreg[15:4];
          n.busy = 1'b0;
          n.st = sadc_pkg::HS_IDLE;
        end
      end
      default:
      begin
        n.st = sadc_pkg::HS_IDLE;
      end
    endcase
  end

  // One register stage holds all host state.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      r <= '0;
    end
    else
    begin
      r <= n;
    end
  end

  assign bus.sclk          = r.sclk;
  assign bus.cs_n          = r.cs_n;
  assign bus.frame_sync_in = r.fs;
  assign busy              = r.busy;
  assign result_valid      = r.valid;
  assign result_data       = r.data;

endmodule // sadc_host

// *** design/sadc_device.sv ***
`timescale 1ns/100ps
module sadc_device (
  input  wire logic                    clk,
  input  wire logic                    rst_n,
  sadc_if.dev                          bus,
  input  wire sadc_pkg::sadc_variant_t variant,
  input  wire logic [11:0]             analog_channel_0,
  input  wire logic [11:0]             analog_channel_1,
  input  wire logic [11:0]             positive_analog_input,
  input  wire logic [11:0]             negative_analog_input,
  output logic                         mux_channel,
  output logic                         powered_up,
  output logic                         sampling,
  output logic                         converting,
  output logic                         conv_done,
  output logic [11:0]                  last_result
);

  // Pin vectors below use bit 0 for the serial clock, bit 1 for select, bit 2 for sync.
  typedef struct packed {
    logic [2:0]             s1;
    logic [2:0]             s2;
    logic [2:0]             s3;
    logic [2:0]             flt;
    sadc_pkg::sadc_dev_st_t st;
    sadc_pkg::sadc_ctrl_t   mode;
    logic                   fs_fell;
    logic [5:0]             cnt;
    logic [3:0]             low_cnt;
    logic                   chan;
    logic [15:0]            shreg;
    logic [11:0]            sample;
    logic [11:0]            result;
    logic                   oe;
    logic                   sampling;
    logic                   converting;
    logic                   powered;
    logic                   done;
  } sadc_dev_t;

  sadc_dev_t  r;
  sadc_dev_t  n;
  logic       sclk_fall;
  logic       sclk_rise;
  logic       cs_fall;
  logic       cs_rise;
  logic       fs_rise;
  logic       fs_fall;
  logic       cs_low;
  logic       fs_high;
  logic       fs_used;
  logic       start_ok;
  logic       end_evt;
  logic [5:0] cnt_inc;
  logic [11:0] code;

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers and edge detection.
  // A pin change is accepted once stages two and three agree, which rejects single-cycle glitches.
  always_comb
  begin
    n = r;
    n.done = 1'b0;
    n.s1 = {bus.frame_sync_in, bus.cs_n, bus.sclk};
    n.s2 = r.s1;
    n.s3 = r.s2;
    n.flt = (r.s2 & r.s3) | (r.flt & (r.s2 ^ r.s3));
    sclk_fall = r.flt[0] & ~n.flt[0];
    sclk_rise = ~r.flt[0] & n.flt[0];
    cs_fall = r.flt[1] & ~n.flt[1];
    cs_rise = ~r.flt[1] & n.flt[1];
    fs_fall = r.flt[2] & ~n.flt[2];
    fs_rise = ~r.flt[2] & n.flt[2];
    cs_low = ~n.flt[1];
    fs_high = n.flt[2];
    // Only the single-channel variant listens to frame sync.
    fs_used = (variant == sadc_pkg::SADC_SINGLE);
    cnt_inc = r.cnt + 6'h01;
    // A sync pulse while only armed re-arms the start; it aborts once the cycle has begun.
    end_evt = cs_rise | (fs_used & fs_rise & (r.mode != sadc_pkg::SADC_CTRL_CS) & (r.st != sadc_pkg::DS_ARMED));
    if (r.mode == sadc_pkg::SADC_CTRL_CS)
    begin
      start_ok = cs_low;
    end
    else
    begin
      start_ok = (r.fs_fell | fs_fall) & ~fs_high;
    end

    // Sample source: selected channel, or the clipped difference of the pseudo pair.
    case (variant)
      sadc_pkg::SADC_DUAL:
      begin
        code = r.chan ? analog_channel_1 : analog_channel_0;
      end
      sadc_pkg::SADC_PSEUDO:
      begin
        code = (positive_analog_input > negative_analog_input) ?
               (positive_analog_input - negative_analog_input) : sadc_pkg::ZERO_CODE;
      end
      default:
      begin
        code = analog_channel_0;
      end
    endcase

    //////////////////////////////////////////////////////////////////////////
    // Channel multiplexer: count serial clocks while selected, act on release.
    if (cs_fall)
    begin
      n.low_cnt = 4'h0;
    end
    else if (cs_low && sclk_fall && r.low_cnt != sadc_pkg::MUX_SAT)
    begin
      n.low_cnt = r.low_cnt + 4'h1;
    end
    if (cs_rise && variant == sadc_pkg::SADC_DUAL)
    begin
      if (r.low_cnt > sadc_pkg::MUX_SHORT_MAX)
      begin
        n.chan = ~r.chan;
      end
      else if (r.low_cnt >= sadc_pkg::MUX_SHORT_MIN)
      begin
        n.chan = 1'b0;
      end
    end

    //////////////////////////////////////////////////////////////////////////
    // Cycle sequencer.
    case (r.st)
      sadc_pkg::DS_DOWN:
      begin
        // Waking preloads the frame with the last finished result, so sampling here feeds the next frame.
        if (cs_fall || (fs_used && fs_rise && cs_low))
        begin
          n.powered = 1'b1;
          n.oe = 1'b1;
          n.shreg = {r.result, sadc_pkg::PAD_BITS};
          n.fs_fell = 1'b0;
          n.st = sadc_pkg::DS_ARMED;
          if (cs_fall)
          begin
            n.mode = (fs_high || !fs_used) ? sadc_pkg::SADC_CTRL_CS : sadc_pkg::SADC_CTRL_BOTH;
          end
          else
          begin
            n.mode = sadc_pkg::SADC_CTRL_FS;
          end
        end
      end
      sadc_pkg::DS_ARMED:
      begin
        if (fs_fall)
        begin
          n.fs_fell = 1'b1;
        end
        // The start is confirmed by the control levels seen at a falling serial clock edge.
        if (sclk_fall && start_ok)
        begin
          n.cnt = 6'h01;
          n.st = sadc_pkg::DS_ACTIVE;
        end
      end
      sadc_pkg::DS_ACTIVE:
      begin
        // The first bit stays put until the host has read it on the first falling edge.
        if (sclk_rise && r.cnt < sadc_pkg::FRAME_BITS)
        begin
          n.shreg = {r.shreg[14:0], 1'b0};
        end
        if (sclk_fall)
        begin
          n.cnt = cnt_inc;
          if (cnt_inc == sadc_pkg::SAMPLE_FIRST)
          begin
            n.sampling = 1'b1;
          end
          if (cnt_inc == sadc_pkg::SAMPLE_FIRST + sadc_pkg::SAMPLE_CLKS - 6'h01)
          begin
            n.sampling = 1'b0;
            n.sample = code;
            n.oe = 1'b0;
            n.converting = 1'b1;
            n.cnt = 6'h00;
            n.st = sadc_pkg::DS_CONV;
          end
        end
      end
      sadc_pkg::DS_CONV:
      begin
        if (sclk_fall)
        begin
          n.cnt = cnt_inc;
          if (cnt_inc == sadc_pkg::CONV_CLKS)
          begin
            n.result = r.sample;
            n.converting = 1'b0;
            n.powered = 1'b0;
            n.done = 1'b1;
            n.st = sadc_pkg::DS_DOWN;
          end
        end
      end
      default:
      begin
        n.st = sadc_pkg::DS_DOWN;
      end
    endcase

    // Releasing a control line mid-cycle throws the pending sample away; the old result stays.
    if (end_evt && r.st != sadc_pkg::DS_DOWN)
    begin
      n.st = sadc_pkg::DS_DOWN;
      n.sampling = 1'b0;
      n.converting = 1'b0;
      n.powered = 1'b0;
      n.done = 1'b0;
    end
    if (cs_rise || end_evt)
    begin
      n.oe = 1'b0;
    end
  end

  // One register stage holds all device state.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      r <= '0;
    end
    else
    begin
      r <= n;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs, all straight from state flip-flops.
  assign bus.sdo     = r.shreg[15];
  assign bus.sdo_oe  = r.oe;
  assign mux_channel = r.chan;
  assign powered_up  = r.powered;
  assign sampling    = r.sampling;
  assign converting  = r.converting;
  assign conv_done   = r.done;
  assign last_result = r.result;

endmodule // sadc_device

// *** verif/sadc_props.sv ***
`timescale 1ns/100ps
module sadc_props (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic frame_sync_in,
  input wire logic sdo,
  input wire logic sdo_oe
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  logic       sclk_reg;
  logic       fs_reg;
  logic [4:0] oe_falls_reg;
  logic [1:0] hi_falls_reg;
  logic [5:0] lo_falls_reg;
  logic       fall;

  ////////////////////////////////////////////////////////////////////////////
  // Falling serial clock edges counted per frame, per select high and low.
  assign fall = sclk_reg & ~sclk;
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sclk_reg     <= 1'b0;
      fs_reg       <= 1'b0;
      oe_falls_reg <= 5'h00;
      hi_falls_reg <= 2'h0;
      lo_falls_reg <= 6'h00;
    end
    else
    begin
      sclk_reg     <= sclk;
      fs_reg       <= frame_sync_in;
      // A sync edge restarts the count, since the frame begins after the sync pulse.
      oe_falls_reg <= (!sdo_oe || (fs_reg != frame_sync_in)) ? 5'h00 :
                      oe_falls_reg + {4'h0, fall & (oe_falls_reg != 5'h1F)};
      hi_falls_reg <= cs_n ? hi_falls_reg + {1'b0, fall & (hi_falls_reg != 2'h3)} : 2'h0;
      lo_falls_reg <= cs_n ? 6'h00 : lo_falls_reg + {5'h00, fall & (lo_falls_reg != 6'h3F)};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // The sync delay in the device is at most four clocks, so six is a safe margin.
  cs_quiet_a: assert property (cs_n [*6] |-> !sdo_oe)
    else $error("data line driven while deselected");
  wake_on_select_a: assert property ($fell(cs_n) |-> ##[1:6] sdo_oe)
    else $error("data line not driven after select fall");
  change_on_rise_a: assert property (sdo_oe && $past(sdo_oe) && $changed(sdo) |-> sclk)
    else $error("data bit changed while serial clock low");
  frame_length_a: assert property (sdo_oe |-> oe_falls_reg <= 5'h10)
    else $error("more than sixteen bits driven");
  release_sixteen_a: assert property ($fell(sdo_oe) && !cs_n |-> $past(oe_falls_reg) == 5'h10)
    else $error("data line released early");
  high_gap_fall_a: assert property ($fell(cs_n) |-> hi_falls_reg != 2'h0)
    else $error("no falling serial clock while deselected");
  hold_whole_cycle_a: assert property ($rose(cs_n) && lo_falls_reg != 6'h00 |-> lo_falls_reg >= 6'h2D)
    else $error("select released before cycle end");
  sclk_half_a: assert property ($rose(sclk) |=> sclk [*8] ##2 $fell(sclk))
    else $error("serial clock high phase wrong");

  cover property ($fell(sdo_oe) && !cs_n);
  cover property ($rose(frame_sync_in) && !cs_n);
  cover property ($rose(cs_n) && lo_falls_reg >= 6'h2D);
endmodule // sadc_props

// *** verif/tb.sv ***
`timescale 1ns/100ps
module tb;
  logic                    clk;
  logic                    rst_n;
  logic                    start;
  sadc_pkg::sadc_ctrl_t    ctrl_mode;
  sadc_pkg::sadc_variant_t variant;
  logic [11:0]             ch0;
  logic [11:0]             ch1;
  logic [11:0]             pos_in;
  logic [11:0]             neg_in;
  logic                    busy;
  logic                    result_valid;
  logic [11:0]             result_data;
  logic                    mux_channel;
  logic                    powered_up;
  logic                    mux2;
  logic [11:0]             last2;
  logic [4:0]              div_reg;
  int                      mismatches;
  int                      samples_checked;

  sadc_if lk();
  sadc_if l2();

  sadc_host i_sadc_host (.clk(clk), .rst_n(rst_n), .bus(lk), .start(start), .ctrl_mode(ctrl_mode),
    .busy(busy), .result_valid(result_valid), .result_data(result_data));
  sadc_device i_sadc_device (.clk(clk), .rst_n(rst_n), .bus(lk), .variant(variant),
    .analog_channel_0(ch0), .analog_channel_1(ch1), .positive_analog_input(pos_in),
    .negative_analog_input(neg_in), .mux_channel(mux_channel), .powered_up(powered_up),
    .sampling(), .converting(), .conv_done(), .last_result());
  // Second device faces the bench, which breaks the cycle rules on purpose.
  sadc_device i_sadc_device_2 (.clk(clk), .rst_n(rst_n), .bus(l2), .variant(sadc_pkg::SADC_DUAL),
    .analog_channel_0(ch0), .analog_channel_1(ch1), .positive_analog_input(12'h000),
    .negative_analog_input(12'h000), .mux_channel(mux2), .powered_up(), .sampling(),
    .converting(), .conv_done(), .last_result(last2));
  sadc_props i_sadc_props (.clk(clk), .rst_n(rst_n), .sclk(lk.sclk), .cs_n(lk.cs_n),
    .frame_sync_in(lk.frame_sync_in), .sdo(lk.sdo), .sdo_oe(lk.sdo_oe));

  ////////////////////////////////////////////////////////////////////////////
  // System clock, and a free serial clock of twenty system clocks for the second link.
  always #10 clk = ~clk;
  always @(posedge clk)
  begin
    div_reg <= (div_reg == 5'h13) ? 5'h00 : div_reg + 5'h01;
    l2.sclk <= (div_reg == 5'h13) || (div_reg < 5'h09);
  end

  ////////////////////////////////////////////////////////////////////////////
  task chk(input logic [11:0] got, input logic [11:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task wrap_up;
    $display("checks=%0d mismatches=%0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // The gap after reset lets the host hold select high across a falling serial clock.
  task do_reset(input sadc_pkg::sadc_variant_t v);
    @(posedge clk);
    rst_n   <= 1'b0;
    variant <= v;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    repeat (60) @(posedge clk);
  endtask

  // One full host cycle; a frame runs about 940 clocks, so 3000 is a generous bound.
  task frame(input sadc_pkg::sadc_ctrl_t m, input logic [11:0] exp);
    int n;
    @(posedge clk);
    ctrl_mode <= m;
    repeat (40) @(posedge clk);
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    n = 0;
    while (result_valid !== 1'b1 && n < 3000)
    begin
      @(negedge clk);
      n++;
    end
    if (n == 3000)
    begin
      mismatches++;
      wrap_up;
    end
    chk(result_data, exp);
    chk({11'h000, powered_up}, 12'h000);
    repeat (30) @(posedge clk);
  endtask

  // Select low for n falling edges on the second link, starting just after a rising edge.
  task cs_low(input int n);
    int k;
    k = 0;
    while (div_reg !== 5'h02 && k < 40)
    begin
      @(posedge clk);
      k++;
    end
    if (k == 40)
    begin
      mismatches++;
      wrap_up;
    end
    l2.cs_n <= 1'b0;
    repeat (n * 20) @(posedge clk);
    l2.cs_n <= 1'b1;
    repeat (60) @(posedge clk);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task t_cs;
    do_reset(sadc_pkg::SADC_SINGLE);
    ch0 <= 12'hFFF;
    frame(sadc_pkg::SADC_CTRL_CS, 12'h000);
    ch0 <= 12'h000;
    frame(sadc_pkg::SADC_CTRL_CS, 12'hFFF);
    ch0 <= 12'hABC;
    frame(sadc_pkg::SADC_CTRL_CS, 12'h000);
    $display("select control test done");
  endtask

  task t_fs;
    ch0 <= 12'h123;
    frame(sadc_pkg::SADC_CTRL_FS, 12'hABC);
    ch0 <= 12'h456;
    frame(sadc_pkg::SADC_CTRL_BOTH, 12'h123);
    frame(sadc_pkg::SADC_CTRL_CS, 12'h456);
    $display("frame sync control test done");
  endtask

  task t_dual;
    do_reset(sadc_pkg::SADC_DUAL);
    ch0 <= 12'h111;
    ch1 <= 12'h222;
    frame(sadc_pkg::SADC_CTRL_CS, 12'h000);
    chk({11'h000, mux_channel}, 12'h001);
    frame(sadc_pkg::SADC_CTRL_CS, 12'h111);
    chk({11'h000, mux_channel}, 12'h000);
    frame(sadc_pkg::SADC_CTRL_CS, 12'h222);
    $display("dual channel test done");
  endtask

  task t_pseudo;
    do_reset(sadc_pkg::SADC_PSEUDO);
    pos_in <= 12'h800;
    neg_in <= 12'h100;
    frame(sadc_pkg::SADC_CTRL_CS, 12'h000);
    pos_in <= 12'h100;
    neg_in <= 12'h800;
    frame(sadc_pkg::SADC_CTRL_CS, 12'h700);
    frame(sadc_pkg::SADC_CTRL_CS, 12'h000);
    $display("pseudo differential test done");
  endtask

  task t_link2;
    ch0 <= 12'h5A5;
    ch1 <= 12'h3C3;
    cs_low(46);
    chk(last2, 12'h5A5);
    chk({11'h000, mux2}, 12'h001);
    cs_low(5);
    chk({11'h000, mux2}, 12'h000);
    ch0 <= 12'h0F0;
    cs_low(20);
    chk(last2, 12'h5A5);
    chk({11'h000, mux2}, 12'h001);
    $display("short select and abort test done");
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence; every input settles at time zero before the first edge.
  initial
  begin
    clk              = 1'b0;
    rst_n            = 1'b0;
    start            = 1'b0;
    ctrl_mode        = sadc_pkg::SADC_CTRL_CS;
    variant          = sadc_pkg::SADC_SINGLE;
    ch0              = 12'h000;
    ch1              = 12'h000;
    pos_in           = 12'h000;
    neg_in           = 12'h000;
    div_reg          = 5'h00;
    l2.sclk          = 1'b0;
    l2.cs_n          = 1'b1;
    l2.frame_sync_in = 1'b1;
    mismatches       = 0;
    samples_checked  = 0;
    t_cs;
    t_fs;
    t_dual;
    t_pseudo;
    t_link2;
    wrap_up;
  end
endmodule // tb
